// ### rtl/bwr_pkg.sv
/*
 * Package for the bus watchdog and reset block: timing counts, command
 * codes and the grouped bus-activity carrier.
 * Assumes a single 25 MHz clock shared by all users of the package.
 */
package bwr_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned SHORT_TMO_S     = 1;
    localparam int unsigned LONG_TMO_S      = 10;
    localparam int unsigned BUS_CLR_MS      = 100;
    localparam int unsigned SYS_RST_MS      = 100;
    localparam int unsigned SHORT_TMO_CYC   = SHORT_TMO_S * CLK_HZ;
    localparam int unsigned LONG_TMO_CYC    = LONG_TMO_S * CLK_HZ;
    localparam int unsigned BUS_CLR_CYC     = BUS_CLR_MS * (CLK_HZ / 1000);
    localparam int unsigned SYS_RST_CYC     = SYS_RST_MS * (CLK_HZ / 1000);

    // ----------------------------------------------------------------
    // Decoded command locations
    // ----------------------------------------------------------------
    localparam logic [15:0] WDOG_ENA_ADDR   = 16'h6080;
    localparam logic [15:0] WDOG_DIS_ADDR   = 16'h60C0;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
    } bwr_cpu_bus_t;

    typedef struct packed {
        logic bus_rst;
        logic full_rst;
    } bwr_rst_cmd_t;

    typedef enum logic [1:0] {
        BWR_IDLE,
        BWR_BUS_CLR,
        BWR_FULL_CLR
    } bwr_state_t;

endpackage

// ### rtl/bwr_bus_watchdog.sv
/*
 * Bus watchdog and reset generator for an expansion-bus controller.
 * Assumes all inputs are synchronous to clk_i, command strobes are single
 * cycle pulses decoded by the controller, and the controller and bus obey
 * the active-low clear and reset outputs.
 */
`timescale 1ns/100ps

module bwr_bus_watchdog
    import bwr_pkg::*;
#(
    parameter int unsigned SHORT_CYC = SHORT_TMO_CYC,
    parameter int unsigned LONG_CYC  = LONG_TMO_CYC,
    parameter int unsigned CLR_CYC   = BUS_CLR_CYC,
    parameter int unsigned RST_CYC   = SYS_RST_CYC
)
(
    input  wire logic         clk_i,
    input  wire logic         reset_n_i,
    input  wire bwr_cpu_bus_t cpu_bus_i,
    input  wire logic         bus_access_i,
    input  wire bwr_rst_cmd_t rst_cmd_i,
    input  wire logic         long_tmo_sel_i,
    input  wire logic         msg_irq_flag_i,
    input  wire logic         msg_valid_i,
    output logic              bus_clear_n_o,
    output logic              ctrl_reset_n_o,
    output logic              ext_irq_o,
    output logic              wdog_running_o
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    localparam int unsigned CW = 32;

    // Pulse ends compare against CYC-1, so a zero length would wrap
    if (SHORT_CYC < 2)
    begin : g_bad_short
        $error("bwr_bus_watchdog: short timeout below two cycles");
    end
    if (LONG_CYC < SHORT_CYC)
    begin : g_bad_long
        $error("bwr_bus_watchdog: long timeout below short timeout");
    end
    if (CLR_CYC < 1 || RST_CYC < 1)
    begin : g_bad_pulse
        $error("bwr_bus_watchdog: clear pulses need at least one cycle");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    bwr_state_t    state_r,    state_nxt;
    logic          run_r,      run_nxt;
    logic          long_r,     long_nxt;
    logic [CW-1:0] wd_cnt_r,   wd_cnt_nxt;
    logic [CW-1:0] pulse_cnt_r, pulse_cnt_nxt;
    logic          clr_n_r,    clr_n_nxt;
    logic          rst_n_r,    rst_n_nxt;
    logic          irq_r,      irq_nxt;

    logic          ena_wr;
    logic          dis_wr;
    logic [CW-1:0] limit;
    logic          tmo_hit;

    // ----------------------------------------------------------------
    // Command decode and timeout compare
    // ----------------------------------------------------------------
    assign ena_wr  = cpu_bus_i.wr && (cpu_bus_i.addr == WDOG_ENA_ADDR);
    assign dis_wr  = cpu_bus_i.wr && (cpu_bus_i.addr == WDOG_DIS_ADDR);
    assign limit   = long_r ? CW'(LONG_CYC) : CW'(SHORT_CYC);
    // Fires on the edge that closes limit idle cycles; an access on that edge still saves it
    assign tmo_hit = run_r && !bus_access_i && (wd_cnt_r >= limit - CW'(1));

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt     = state_r;
        run_nxt       = run_r;
        long_nxt      = long_r;
        wd_cnt_nxt    = wd_cnt_r;
        pulse_cnt_nxt = pulse_cnt_r;
        clr_n_nxt     = clr_n_r;
        rst_n_nxt     = rst_n_r;
        irq_nxt       = msg_irq_flag_i && msg_valid_i;

        // Config only moves while idle so a live timeout never changes length
        if (!run_r)
        begin
            long_nxt = long_tmo_sel_i;
        end

        // Disable, a full reset or a timeout stops the count; error or abort have no input here
        if (dis_wr)
        begin
            run_nxt    = 1'b0;
            wd_cnt_nxt = '0;
        end
        else if (ena_wr && !run_r)
        begin
            // A second arm while running does not restart the count
            run_nxt    = 1'b1;
            wd_cnt_nxt = '0;
        end
        else if (run_r)
        begin
            if (bus_access_i)
            begin
                wd_cnt_nxt = '0;
            end
            else
            begin
                wd_cnt_nxt = wd_cnt_r + CW'(1);
            end
        end

        unique case (state_r)
            BWR_IDLE:
            begin
                clr_n_nxt = 1'b1;
                rst_n_nxt = 1'b1;
                if (rst_cmd_i.full_rst || tmo_hit)
                begin
                    state_nxt     = BWR_FULL_CLR;
                    pulse_cnt_nxt = '0;
                    clr_n_nxt     = 1'b0;
                    rst_n_nxt     = 1'b0;
                    run_nxt       = 1'b0;
                    wd_cnt_nxt    = '0;
                end
                else if (rst_cmd_i.bus_rst)
                begin
                    state_nxt     = BWR_BUS_CLR;
                    pulse_cnt_nxt = '0;
                    clr_n_nxt     = 1'b0;
                end
            end
            BWR_BUS_CLR:
            begin
                // Reset commands are ignored until this pulse ends
                pulse_cnt_nxt = pulse_cnt_r + CW'(1);
                if (pulse_cnt_r == CW'(CLR_CYC - 1))
                begin
                    state_nxt = BWR_IDLE;
                    clr_n_nxt = 1'b1;
                end
            end
            BWR_FULL_CLR:
            begin
                // Controller held in reset too, so watchdog forced off
                run_nxt       = 1'b0;
                wd_cnt_nxt    = '0;
                pulse_cnt_nxt = pulse_cnt_r + CW'(1);
                if (pulse_cnt_r == CW'(RST_CYC - 1))
                begin
                    state_nxt = BWR_IDLE;
                    clr_n_nxt = 1'b1;
                    rst_n_nxt = 1'b1;
                end
            end
            default:
            begin
                state_nxt = BWR_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_r     <= BWR_IDLE;
            run_r       <= 1'b0;
            long_r      <= 1'b0;
            wd_cnt_r    <= '0;
            pulse_cnt_r <= '0;
            clr_n_r     <= 1'b1;
            rst_n_r     <= 1'b1;
            irq_r       <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            run_r       <= run_nxt;
            long_r      <= long_nxt;
            wd_cnt_r    <= wd_cnt_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
            clr_n_r     <= clr_n_nxt;
            rst_n_r     <= rst_n_nxt;
            irq_r       <= irq_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Driven straight from flops so no decode glitch can pulse the bus clear
    assign bus_clear_n_o  = clr_n_r;
    assign ctrl_reset_n_o = rst_n_r;
    assign ext_irq_o      = irq_r;
    assign wdog_running_o = run_r;

endmodule

// ### dv/bwr_sva.sv
/* Port checker for the bus watchdog and reset block.
   Assumes pulse parameters of 5 cycles and short timeout above 9. */
`timescale 1ns/100ps
module bwr_sva
    import bwr_pkg::*;
(
    input wire logic         clk_i,
    input wire logic         reset_n_i,
    input wire bwr_cpu_bus_t cpu_bus_i,
    input wire logic         bus_access_i,
    input wire bwr_rst_cmd_t rst_cmd_i,
    input wire logic         long_tmo_sel_i,
    input wire logic         msg_irq_flag_i,
    input wire logic         msg_valid_i,
    input wire logic         bus_clear_n_o,
    input wire logic         ctrl_reset_n_o,
    input wire logic         ext_irq_o,
    input wire logic         wdog_running_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire logic ena_w = cpu_bus_i.wr && cpu_bus_i.addr == WDOG_ENA_ADDR;
    wire logic dis_w = cpu_bus_i.wr && cpu_bus_i.addr == WDOG_DIS_ADDR;
    a_irq_on_msg: assert property (msg_valid_i && msg_irq_flag_i |=> ext_irq_o)
        else $error("irq missing after message");
    a_irq_needs_flag: assert property (!(msg_valid_i && msg_irq_flag_i) |=> !ext_irq_o)
        else $error("irq without flagged message");
    a_arm_write: assert property (ena_w && !wdog_running_o && ctrl_reset_n_o && !rst_cmd_i.full_rst
        |=> wdog_running_o) else $error("arm write ignored");
    a_disarm_write: assert property (dis_w |=> !wdog_running_o)
        else $error("disarm write ignored");
    a_stay_idle: assert property (!ena_w && !wdog_running_o |=> !wdog_running_o)
        else $error("watchdog armed itself");
    a_bus_clr_len: assert property ($fell(bus_clear_n_o) && ctrl_reset_n_o
        |-> !bus_clear_n_o [*5] ##1 bus_clear_n_o) else $error("bus clear length");
    a_bus_cmd_fire: assert property (rst_cmd_i.bus_rst && !rst_cmd_i.full_rst && bus_clear_n_o
        && !wdog_running_o |=> !bus_clear_n_o && ctrl_reset_n_o) else $error("bus reset");
    a_full_fire: assert property (rst_cmd_i.full_rst && ctrl_reset_n_o && bus_clear_n_o
        |=> !ctrl_reset_n_o && !bus_clear_n_o) else $error("full reset missing");
    a_full_len: assert property ($fell(ctrl_reset_n_o) |-> (!ctrl_reset_n_o && !bus_clear_n_o
        && !wdog_running_o) [*5] ##1 ctrl_reset_n_o) else $error("full reset length");
    a_access_hold: assert property (wdog_running_o && bus_access_i |=> ctrl_reset_n_o [*8])
        else $error("reset soon after bus access");
    a_clear_idle: assert property (!wdog_running_o && !rst_cmd_i.bus_rst && !rst_cmd_i.full_rst
        && bus_clear_n_o |=> bus_clear_n_o) else $error("spurious bus clear");
endmodule
bind bwr_bus_watchdog bwr_sva bwr_sva_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .cpu_bus_i(cpu_bus_i),
    .bus_access_i(bus_access_i), .rst_cmd_i(rst_cmd_i), .long_tmo_sel_i(long_tmo_sel_i),
    .msg_irq_flag_i(msg_irq_flag_i), .msg_valid_i(msg_valid_i), .bus_clear_n_o(bus_clear_n_o),
    .ctrl_reset_n_o(ctrl_reset_n_o), .ext_irq_o(ext_irq_o), .wdog_running_o(wdog_running_o));

// ### dv/bwr_periph_model.sv
/* Expansion-bus peripheral: one access every 4 cycles while active.
   Assumes peripherals stay silent while the bus clear is held low. */
`timescale 1ns/100ps
module bwr_periph_model (
    input  wire logic clk_i,
    input  wire logic active_i,
    input  wire logic bus_clear_n_i,
    output logic      bus_access_o
);
    logic [1:0] cnt_r = 2'h0;
    initial bus_access_o = 1'b0;
    always @(negedge clk_i)
    begin
        cnt_r <= cnt_r + 2'h1;
        bus_access_o <= active_i && bus_clear_n_i && cnt_r == 2'h0;
    end
endmodule

// ### dv/tb_top.sv
/* Bench for the bus watchdog with shortened counts.
   Assumes the peripheral model answers on the expansion bus side. */
`timescale 1ns/100ps
module tb_top;
    import bwr_pkg::*;
    localparam int SC = 20, LC = 50, PC = 5;
    logic clk_i = 0, reset_n_i = 0, long_tmo_sel_i = 0, msg_irq_flag_i = 0, msg_valid_i = 0, active = 0;
    bwr_cpu_bus_t cpu_bus_i = '0;
    bwr_rst_cmd_t rst_cmd_i = '0;
    logic bus_access_i, bus_clear_n_o, ctrl_reset_n_o, ext_irq_o, wdog_running_o;
    int bad_count = 0, checked = 0, cyc = 0, n = 0;
    initial forever #20 clk_i = ~clk_i;
    bwr_bus_watchdog #(.SHORT_CYC(SC), .LONG_CYC(LC), .CLR_CYC(PC), .RST_CYC(PC)) bwr_bus_watchdog_inst (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .cpu_bus_i(cpu_bus_i), .bus_access_i(bus_access_i),
        .rst_cmd_i(rst_cmd_i), .long_tmo_sel_i(long_tmo_sel_i), .msg_irq_flag_i(msg_irq_flag_i),
        .msg_valid_i(msg_valid_i), .bus_clear_n_o(bus_clear_n_o), .ctrl_reset_n_o(ctrl_reset_n_o),
        .ext_irq_o(ext_irq_o), .wdog_running_o(wdog_running_o));
    bwr_periph_model bwr_periph_model_inst (.clk_i(clk_i), .active_i(active),
        .bus_clear_n_i(bus_clear_n_o), .bus_access_o(bus_access_i));
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
        checked++;
        if (s !== e)
        begin
            $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
            bad_count++;
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk_i);
    endtask
    task automatic wr(input logic [15:0] a);
        cpu_bus_i = '{1'b1, 1'b0, a};
        tick(1);
        cpu_bus_i = '0;
        // Idle cycle so a following write never retoggles the strobe in one step
        tick(1);
    endtask
    // Counts low cycles of the chosen reset output, bounded
    task automatic cnt_low(input bit ctrl);
        n = 0;
        while ((ctrl ? ctrl_reset_n_o : bus_clear_n_o) === 1'b0 && n < 999)
        begin
            n++;
            tick(1);
        end
    endtask
    task automatic t_bus_rst();
        rst_cmd_i.bus_rst = 1'b1;
        tick(1);
        rst_cmd_i.bus_rst = 1'b0;
        cmp("ctrl kept", 8'h01, ctrl_reset_n_o);
        cnt_low(0);
        cmp("bus clear len", PC, n);
    endtask
    task automatic t_full_rst();
        rst_cmd_i.full_rst = 1'b1;
        tick(1);
        rst_cmd_i.full_rst = 1'b0;
        cmp("clear in full", 8'h00, bus_clear_n_o);
        cnt_low(1);
        cmp("full len", PC, n);
    endtask
    task automatic t_tmo(input logic sel, input int lim);
        long_tmo_sel_i = sel;
        tick(1);
        wr(WDOG_ENA_ADDR);
        long_tmo_sel_i = ~sel;
        cmp("armed", 8'h01, wdog_running_o);
        active = 1'b1;
        tick(3 * lim);
        cmp("no reset while busy", 8'h01, ctrl_reset_n_o);
        active = 1'b0;
        n = 0;
        while (ctrl_reset_n_o === 1'b1 && n < 999)
        begin
            n++;
            tick(1);
        end
        cmp("timeout span", 8'h01, n >= lim - 5 && n <= lim + 1);
        cmp("disarmed", 8'h00, wdog_running_o);
        cmp("tmo bus clear", 8'h00, bus_clear_n_o);
        cnt_low(1);
    endtask
    task automatic t_disarm();
        wr(WDOG_ENA_ADDR);
        cmp("rearm", 8'h01, wdog_running_o);
        wr(WDOG_DIS_ADDR);
        cmp("disarm", 8'h00, wdog_running_o);
        tick(2 * SC);
        cmp("idle no reset", 8'h01, ctrl_reset_n_o);
    endtask
    task automatic t_msg(input logic flag);
        msg_irq_flag_i = flag;
        msg_valid_i = 1'b1;
        tick(1);
        msg_valid_i = 1'b0;
        cmp("irq", flag, ext_irq_o);
        tick(1);
        cmp("irq pulse", 8'h00, ext_irq_o);
    endtask
    task automatic t_rst_release();
        reset_n_i = 1'b1;
        tick(1);
        cmp("reset outs", 8'h03, {ext_irq_o, wdog_running_o, bus_clear_n_o, ctrl_reset_n_o});
    endtask
    // Reset pulled while armed: the watchdog must come back disarmed and stay so
    task automatic t_mid_rst();
        wr(WDOG_ENA_ADDR);
        cmp("armed before reset", 8'h01, wdog_running_o);
        reset_n_i = 1'b0;
        tick(2);
        cmp("outs in reset", 8'h03, {ext_irq_o, wdog_running_o, bus_clear_n_o, ctrl_reset_n_o});
        t_rst_release();
        tick(2 * SC);
        cmp("no rearm after reset", 8'h01, ctrl_reset_n_o);
        cmp("still disarmed", 8'h00, wdog_running_o);
    endtask
    task automatic final_report();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            final_report();
        end
    end
    initial
    begin
        tick(6);
        t_rst_release();
        t_bus_rst();
        t_full_rst();
        t_tmo(1'b0, SC);
        t_tmo(1'b1, LC);
        t_disarm();
        t_mid_rst();
        t_msg(1'b1);
        t_msg(1'b0);
        final_report();
    end
endmodule
